// ==== slp_pkg.sv ====
// slp_pkg: constants and carrier types of the status lamp block
`default_nettype none
package slp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned WDT_TICK_NS = 100000;
  localparam int unsigned WDT_TICK_CYC = WDT_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_WDT_LIM = 8'h08;
  localparam logic [7:0] OFS_ERR_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_FORCE = 1;
  localparam int CFG_IOV_STOP = 0;
  localparam int CFG_POS_STOP = 1;
  localparam int CFG_OPE_STOP = 2;
  localparam int CFG_BAT_ALARM = 3;
  localparam int CFG_DUP_OFF = 4;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [4:0] CFG_RST = 5'h0F;
  localparam logic [15:0] WDT_LIM_RST = 16'h07D0;

  localparam int NERR = 6;
  localparam int ERR_GEN = 0;
  localparam int ERR_IOV = 1;
  localparam int ERR_POS = 2;
  localparam int ERR_OPE = 3;
  localparam int ERR_BAT = 4;
  localparam int ERR_DUP = 5;
  localparam int ST_EXP_ACC = 6;
  localparam int ST_EXP_LOST = 7;
  localparam int ST_WDT = 8;

  localparam int IRQ_STOP = 0;
  localparam int IRQ_RUN = 1;
  localparam int IRQ_WDT = 2;
  localparam int IRQ_EXP = 3;

  typedef enum logic [2:0] {
    MODE_PROGRAM_MODE_LAMP = 3'b000,
    MODE_RUN = 3'b001,
    MODE_FORCE = 3'b010,
    MODE_ERR_RUN = 3'b011,
    MODE_ERR_STOP = 3'b100,
    MODE_WDT = 3'b101
  } slp_mode_t;

  typedef struct packed {
    logic run;
    logic program_mode_lamp;
    logic fault;
  } slp_main_lamps_t;

  typedef struct packed {
    logic power;
    logic link;
    logic fault;
  } slp_adp_lamps_t;

  // one-cycle error event pulses, general in bit 0
  typedef struct packed {
    logic dup_output;
    logic battery;
    logic operation;
    logic position;
    logic io_verify;
    logic general;
  } slp_diag_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } slp_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } slp_ahb_rsp_t;
endpackage
`default_nettype wire

// ==== slp_tick_div.sv ====
// slp_tick_div: free-running divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module slp_tick_div #(
  parameter int unsigned DIV = 4000
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  typedef struct packed {
    logic [23:0] cnt;
  } slp_div_state_t;

  slp_div_state_t s_q;
  slp_div_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == 24'(DIV - 1)) begin
      s_d.cnt = 24'h000000;
    end else begin
      s_d.cnt = s_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = (s_q.cnt == 24'(DIV - 1));
endmodule
`default_nettype wire

// ==== slp_status_lamp.sv ====
// slp_status_lamp: self-diagnosis lamp driver with AHB-Lite registers
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module slp_status_lamp
  import slp_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYCLES = slp_pkg::FLASH_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire slp_pkg::slp_ahb_req_t ahb_req,
  output slp_pkg::slp_ahb_rsp_t ahb_rsp,
  input wire slp_pkg::slp_diag_t diag,
  input wire logic scan_begin,
  input wire logic scan_end,
  input wire logic exp_present,
  input wire logic exp_access_err,
  output slp_pkg::slp_main_lamps_t lamp,
  output slp_pkg::slp_adp_lamps_t alamp,
  output logic exec_run,
  output logic exp_halt,
  output logic irq
);
  typedef struct packed {
    logic [1:0] ctrl;
    logic [4:0] cfg;
    logic [15:0] wdt_lim;
    logic [NERR-1:0] err;
    logic wdt_trip;
    logic [15:0] wdt_cnt;
    logic scan_act;
    logic boot_done;
    logic exp_boot;
    logic exp_acc;
    logic exp_lost;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic flash;
    slp_mode_t mode;
    slp_main_lamps_t lamp;
    slp_adp_lamps_t alamp;
    logic exec;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } slp_state_t;

  slp_state_t s_q;
  slp_state_t s_d;
  logic wdt_tick;
  logic flash_tick;
  logic [NERR-1:0] stop_mask;
  logic [NERR-1:0] ev;
  logic [NERR-1:0] err_clr;
  logic stop_err;
  logic run_err;
  logic wdt_hit;
  logic ap;
  logic wr;
  logic [3:0] irq_ev;

  slp_tick_div #(.DIV(WDT_TICK_CYC)) u_wdt_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(wdt_tick)
  );

  // lamp flash rate is slow; a parameter so a simulation can shorten it
  slp_tick_div #(.DIV(FLASH_HALF_CYCLES)) u_flash_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(flash_tick)
  );

  always_comb begin
    s_d = s_q;
    // general and duplicated-output errors always stop
    stop_mask = 6'h21;
    stop_mask[ERR_IOV] = s_q.cfg[CFG_IOV_STOP];
    stop_mask[ERR_POS] = s_q.cfg[CFG_POS_STOP];
    stop_mask[ERR_OPE] = s_q.cfg[CFG_OPE_STOP];
    ev = diag;
    ev[ERR_BAT] = diag.battery && s_q.cfg[CFG_BAT_ALARM];
    ev[ERR_DUP] = diag.dup_output && !s_q.cfg[CFG_DUP_OFF];
    stop_err = |(s_q.err & stop_mask);
    run_err = |(s_q.err & ~stop_mask);
    ap = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    wr = s_q.dp_act && s_q.dp_wr;
    err_clr = '0;
    irq_ev = '0;

    // register writes land in the data phase
    if (wr) begin
      case (s_q.dp_addr)
        OFS_CTRL: s_d.ctrl = ahb_req.hwdata[1:0];
        OFS_CFG: s_d.cfg = ahb_req.hwdata[4:0];
        OFS_WDT_LIM: s_d.wdt_lim = ahb_req.hwdata[15:0];
        OFS_IRQ_MASK: s_d.irq_mask = ahb_req.hwdata[3:0];
        OFS_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~ahb_req.hwdata[3:0];
        OFS_ERR_STAT: begin
          // stopping errors may only be cleared in program mode
          err_clr = ahb_req.hwdata[NERR-1:0];
          if (s_q.ctrl[CTRL_RUN]) begin
            err_clr = err_clr & ~stop_mask;
          end
          if (ahb_req.hwdata[ST_EXP_ACC]) begin
            s_d.exp_acc = 1'b0;
          end
          if (ahb_req.hwdata[ST_EXP_LOST]) begin
            s_d.exp_lost = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // set wins over the write-one clear
    s_d.err = (s_q.err & ~err_clr) | ev;
    irq_ev[IRQ_STOP] = |(ev & stop_mask & ~s_q.err);
    irq_ev[IRQ_RUN] = |(ev & ~stop_mask & ~s_q.err);

    // adapter: catch presence once after reset release
    s_d.boot_done = 1'b1;
    if (!s_q.boot_done) begin
      s_d.exp_boot = exp_present;
    end
    if (exp_access_err && exp_present) begin
      s_d.exp_acc = 1'b1;
      irq_ev[IRQ_EXP] = !s_q.exp_acc;
    end
    if (s_q.boot_done && s_q.exp_boot && !exp_present) begin
      s_d.exp_lost = 1'b1;
      irq_ev[IRQ_EXP] = irq_ev[IRQ_EXP] || !s_q.exp_lost;
    end

    // watchdog counts 100 us ticks within one program pass
    wdt_hit = s_q.exec && s_q.scan_act && (s_q.wdt_cnt >= s_q.wdt_lim);
    if (scan_begin) begin
      s_d.scan_act = 1'b1;
      s_d.wdt_cnt = 16'h0000;
    end else if (scan_end) begin
      s_d.scan_act = 1'b0;
      s_d.wdt_cnt = 16'h0000;
    end else if (s_q.exec && s_q.scan_act && wdt_tick && s_q.wdt_cnt != 16'hFFFF) begin
      s_d.wdt_cnt = s_q.wdt_cnt + 16'h0001;
    end
    // only a reset recovers from a watchdog trip
    if (wdt_hit) begin
      s_d.wdt_trip = 1'b1;
      irq_ev[IRQ_WDT] = !s_q.wdt_trip;
    end

    s_d.irq_stat = s_d.irq_stat | irq_ev;
    s_d.exec = s_d.ctrl[CTRL_RUN] && !(|(s_d.err & stop_mask)) && !s_d.wdt_trip;

    // display mode, highest priority first
    if (s_q.wdt_trip) begin
      s_d.mode = MODE_WDT;
    end else if (stop_err || (run_err && !s_q.ctrl[CTRL_RUN])) begin
      s_d.mode = MODE_ERR_STOP;
    end else if (run_err) begin
      s_d.mode = MODE_ERR_RUN;
    end else if (s_q.ctrl[CTRL_RUN] && s_q.ctrl[CTRL_FORCE]) begin
      s_d.mode = MODE_FORCE;
    end else if (s_q.ctrl[CTRL_RUN]) begin
      s_d.mode = MODE_RUN;
    end else begin
      s_d.mode = MODE_PROGRAM_MODE_LAMP;
    end

    s_d.flash = s_q.flash ^ flash_tick;
    case (s_d.mode)
      MODE_RUN: s_d.lamp = '{run: 1'b1, program_mode_lamp: 1'b0, fault: 1'b0};
      MODE_FORCE: s_d.lamp = '{run: s_q.flash, program_mode_lamp: !s_q.flash, fault: 1'b0};
      MODE_ERR_RUN: s_d.lamp = '{run: 1'b1, program_mode_lamp: 1'b0, fault: s_q.flash};
      MODE_ERR_STOP: s_d.lamp = '{run: 1'b0, program_mode_lamp: 1'b1, fault: s_q.flash};
      MODE_WDT: s_d.lamp = '{run: 1'b0, program_mode_lamp: 1'b1, fault: 1'b1};
      default: s_d.lamp = '{run: 1'b0, program_mode_lamp: 1'b1, fault: 1'b0};
    endcase

    s_d.alamp.power = 1'b1;
    if (!exp_present || s_q.exp_lost) begin
      s_d.alamp.link = s_q.flash;
    end else begin
      s_d.alamp.link = 1'b1;
    end
    s_d.alamp.fault = (s_q.exp_acc || s_q.exp_lost) ? s_q.flash : 1'b0;

    // address phase captures the read data for the next cycle
    s_d.dp_act = ap;
    s_d.dp_wr = ahb_req.hwrite;
    s_d.dp_addr = ahb_req.haddr[7:0];
    s_d.rdata = 32'h00000000;
    if (ap && !ahb_req.hwrite) begin
      case (ahb_req.haddr[7:0])
        OFS_CTRL: s_d.rdata = {30'h00000000, s_q.ctrl};
        OFS_CFG: s_d.rdata = {27'h0000000, s_q.cfg};
        OFS_WDT_LIM: s_d.rdata = {16'h0000, s_q.wdt_lim};
        OFS_ERR_STAT: s_d.rdata = {23'h000000, s_q.wdt_trip, s_q.exp_lost, s_q.exp_acc, s_q.err};
        OFS_IRQ_STAT: s_d.rdata = {28'h0000000, s_q.irq_stat};
        OFS_IRQ_MASK: s_d.rdata = {28'h0000000, s_q.irq_mask};
        OFS_STATE: s_d.rdata = {s_q.wdt_cnt, 5'h00, exp_present, s_q.exec,
                                s_q.alamp, s_q.lamp, s_q.mode};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.cfg <= CFG_RST;
      s_q.wdt_lim <= WDT_LIM_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ahb_rsp.hrdata = s_q.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;
  assign lamp = s_q.lamp;
  assign alamp = s_q.alamp;
  assign exec_run = s_q.exec;
  assign exp_halt = s_q.exp_acc || s_q.exp_lost;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_program_mode_lamp_lamps;
    (!s_q.wdt_trip && s_q.err == '0 && !s_q.ctrl[CTRL_RUN])
      |=> (!lamp.run && lamp.program_mode_lamp && !lamp.fault);
  endproperty
  a_program_mode_lamp_lamps: assert property (p_program_mode_lamp_lamps) else $error("program mode lamps wrong");

  property p_force_alt;
    (!s_q.wdt_trip && s_q.err == '0 && s_q.ctrl == 2'h3)
      |=> (lamp.run == $past(s_q.flash) && lamp.program_mode_lamp != lamp.run && !lamp.fault);
  endproperty
  a_force_alt: assert property (p_force_alt) else $error("forced run lamps not alternating");

  property p_run_err;
    (!s_q.wdt_trip && !stop_err && run_err && s_q.ctrl[CTRL_RUN])
      |=> (lamp.run && !lamp.program_mode_lamp && lamp.fault == $past(s_q.flash) && $past(exec_run));
  endproperty
  a_run_err: assert property (p_run_err) else $error("running error pattern wrong");

  property p_stop_err;
    (!s_q.wdt_trip && stop_err)
      |=> (!lamp.run && lamp.program_mode_lamp && lamp.fault == $past(s_q.flash) && !exec_run);
  endproperty
  a_stop_err: assert property (p_stop_err) else $error("stopping error pattern wrong");

  sequence s_wdt_hit;
    s_q.exec && s_q.scan_act && s_q.wdt_cnt >= s_q.wdt_lim;
  endsequence
  sequence s_wdt_shown;
    s_q.wdt_trip && !exec_run ##1 (!lamp.run && lamp.program_mode_lamp && lamp.fault);
  endsequence
  property p_wdt;
    s_wdt_hit |=> s_wdt_shown;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog trip not shown");

  property p_wdt_stop;
    s_q.wdt_trip |=> (s_q.wdt_trip && !exec_run);
  endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("execution after watchdog trip");

  property p_exp_absent;
    (!exp_present && !s_q.exp_acc && !s_q.exp_lost)
      |=> (alamp.power && alamp.link == $past(s_q.flash) && !alamp.fault);
  endproperty
  a_exp_absent: assert property (p_exp_absent) else $error("absent module lamps wrong");

  property p_exp_acc;
    (exp_present && s_q.exp_acc && !s_q.exp_lost)
      |=> (alamp.power && alamp.link && alamp.fault == $past(s_q.flash) &&
           (exp_halt || $past(wr && s_q.dp_addr == OFS_ERR_STAT &&
                              ahb_req.hwdata[ST_EXP_ACC])));
  endproperty
  a_exp_acc: assert property (p_exp_acc) else $error("access error lamps wrong");

  property p_lost;
    (s_q.boot_done && s_q.exp_boot && !exp_present) |=> (s_q.exp_lost ##1 exp_halt);
  endproperty
  a_lost: assert property (p_lost) else $error("removed module not flagged");

  property p_set_wins;
    (diag.general && wr && s_q.dp_addr == OFS_ERR_STAT) |=> s_q.err[ERR_GEN];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("error event lost to clear");
endmodule
`default_nettype wire

// ==== slp_exp_model.sv ====
// slp_exp_model: expansion module seen from the adapter link
`timescale 1ns/1ps
`default_nettype none
module slp_exp_model (
  input wire logic hclk,
  input wire logic attach,
  input wire logic glitch,
  output logic exp_present,
  output logic exp_access_err
);
  // a failed access only exists while a module sits on the link
  always_ff @(posedge hclk) begin
    exp_present <= attach;
    exp_access_err <= glitch & attach;
  end
endmodule
`default_nettype wire

// ==== slp_status_lamp_tb.sv ====
// slp_status_lamp_tb: self-checking bench for the status lamp block
`timescale 1ns/1ps
`default_nettype none
module slp_status_lamp_tb;
  import slp_pkg::*;
  localparam int FH = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic m_sel = 1'b0;
  logic [31:0] m_addr = 32'h0;
  logic [1:0] m_trans = 2'h0;
  logic m_wr = 1'b0;
  logic [31:0] m_wdata = 32'h0;
  logic [31:0] rd_q;
  logic [31:0] v;
  slp_ahb_rsp_t rsp;
  slp_diag_t diag = '0;
  logic scan_begin = 1'b0;
  logic scan_end = 1'b0;
  logic attach = 1'b1;
  logic glitch = 1'b0;
  logic exp_present;
  logic exp_access_err;
  logic exec_run;
  logic exp_halt;
  logic irq;
  slp_main_lamps_t lamp;
  slp_adp_lamps_t alamp;
  int failures = 0;
  int samples_checked = 0;
  int seed = 32'h547681C4;
  logic [4:0] cfg;
  logic st;
  initial forever #12.5 hclk = ~hclk;
  always @(posedge hclk) rd_q <= rsp.hrdata;
  slp_exp_model exp_u (.hclk(hclk), .attach(attach), .glitch(glitch),
    .exp_present(exp_present), .exp_access_err(exp_access_err));
  slp_status_lamp #(.FLASH_HALF_CYCLES(FH)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .ahb_req({m_sel, m_addr, m_trans, m_wr, 3'h2, m_wdata, rsp.hreadyout}), .ahb_rsp(rsp),
    .diag(diag), .scan_begin(scan_begin), .scan_end(scan_end), .exp_present(exp_present),
    .exp_access_err(exp_access_err), .lamp(lamp), .alamp(alamp), .exec_run(exec_run),
    .exp_halt(exp_halt), .irq(irq));

  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic done(string s);
    $display("test %s finished, failures so far %0d", s, failures);
  endtask
  // one single transfer; read data taken at the edge that ends the data phase
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    m_sel <= 1'b1;
    m_trans <= 2'h2;
    m_addr <= {24'h0, a};
    m_wr <= w;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    m_sel <= 1'b0;
    m_trans <= 2'h0;
    m_wdata <= d;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    #1 r = rd_q;
    chk("hresp", 32'h0, {31'h0, rsp.hresp});
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    bus(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask
  task automatic pulse(slp_diag_t p);
    @(posedge hclk);
    diag <= p;
    @(posedge hclk);
    diag <= '0;
  endtask
  // lamps {run,program_mode_lamp,fault,power,link,fault}: steady-on and flashing sets over two periods
  task automatic look(string nm, logic [5:0] m, logic [5:0] on, logic [5:0] fl);
    logic [5:0] a;
    logic [5:0] o;
    repeat (4) @(posedge hclk);
    a = '1;
    o = '0;
    repeat (4 * FH) begin
      @(posedge hclk);
      #1;
      a = a & {lamp, alamp};
      o = o | {lamp, alamp};
    end
    chk(nm, {20'h0, on & m, fl & m}, {20'h0, a & m, o & ~a & m});
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  function automatic logic stops(int c, logic [4:0] f);
    return (c == ERR_GEN) ? 1'b1 : f[c - 1];
  endfunction

  initial begin
    do_reset();
    look("program_mode_lamp lamps", 6'h3F, 6'b010110, 6'h0);
    rd(OFS_CTRL, {30'h0, CTRL_RST}, "ctrl reset");
    rd(OFS_CFG, {27'h0, CFG_RST}, "cfg reset");
    rd(OFS_WDT_LIM, {16'h0, WDT_LIM_RST}, "wdt limit reset");
    rd(OFS_IRQ_MASK, 32'h0, "mask reset");
    wr(8'h1C, $random(seed));
    rd(8'h1C, 32'h0, "unmapped");
    wr(OFS_CTRL, 32'h2);
    look("program_mode_lamp force", 6'h3F, 6'b010110, 6'h0);
    wr(OFS_CTRL, 32'h1);
    look("normal run", 6'h3F, 6'b100110, 6'h0);
    chk("exec run", 1, exec_run);
    rd(OFS_STATE, 32'h000007A1, "state normal run");
    wr(OFS_CTRL, 32'h3);
    look("forced run", 6'h38, 6'h0, 6'b110000);
    chk("alternate", 1, lamp.run ^ lamp.program_mode_lamp);
    done("modes");
    wr(OFS_IRQ_MASK, 32'hF);
    for (int i = 0; i < 8; i++) begin
      cfg = {2'b00, 3'($random(seed))};
      st = stops(i % 4, cfg);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_ERR_STAT, 32'hFF);
      wr(OFS_IRQ_STAT, 32'hF);
      wr(OFS_CFG, {27'h0, cfg});
      wr(OFS_CTRL, 32'h1);
      pulse(slp_diag_t'(6'(1 << (i % 4))));
      look("error lamps", 6'h38, st ? 6'b010000 : 6'b100000, 6'b001000);
      chk("exec after error", !st, exec_run);
      chk("irq raised", 1, irq);
      rd(OFS_IRQ_STAT, st ? 32'h1 : 32'h2, "irq status");
    end
    wr(OFS_IRQ_MASK, 32'h0);
    chk("irq masked", 0, irq);
    wr(OFS_IRQ_MASK, 32'hF);
    chk("irq unmasked", 1, irq);
    wr(OFS_IRQ_STAT, 32'hF);
    rd(OFS_IRQ_STAT, 32'h0, "irq cleared");
    chk("irq low", 0, irq);
    done("errors");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_ERR_STAT, 32'hFF);
    wr(OFS_CFG, 32'h07);
    pulse(6'h30);
    rd(OFS_ERR_STAT, 32'h20, "alarm off");
    wr(OFS_ERR_STAT, 32'hFF);
    wr(OFS_CFG, 32'h18);
    pulse(6'h30);
    rd(OFS_ERR_STAT, 32'h10, "alarm on");
    // general error arrives in the very cycle that software clears it
    fork
      wr(OFS_ERR_STAT, 32'h01);
      begin
        repeat (2) @(posedge hclk);
        diag <= 6'h01;
        @(posedge hclk);
        diag <= '0;
      end
    join
    rd(OFS_ERR_STAT, 32'h11, "set beats clear");
    done("settings");
    @(posedge hclk);
    glitch <= 1'b1;
    @(posedge hclk);
    glitch <= 1'b0;
    look("access error", 6'h07, 6'b000110, 6'b000001);
    chk("halt on access", 1, exp_halt);
    wr(OFS_ERR_STAT, 32'h40);
    @(posedge hclk);
    attach <= 1'b0;
    look("removed", 6'h07, 6'b000100, 6'b000011);
    chk("halt on removal", 1, exp_halt);
    do_reset();
    look("absent", 6'h07, 6'b000100, 6'b000010);
    chk("no halt", 0, exp_halt);
    done("adapter");
    wr(OFS_CFG, 32'h0);
    wr(OFS_WDT_LIM, 32'h2);
    wr(OFS_CTRL, 32'h1);
    pulse(6'h08);
    @(posedge hclk);
    scan_begin <= 1'b1;
    @(posedge hclk);
    scan_begin <= 1'b0;
    repeat (10) @(posedge hclk);
    scan_end <= 1'b1;
    @(posedge hclk);
    scan_end <= 1'b0;
    repeat (9000) @(posedge hclk);
    chk("short pass", 1, exec_run);
    scan_begin <= 1'b1;
    @(posedge hclk);
    scan_begin <= 1'b0;
    for (int k = 0; k < 13000 && exec_run === 1'b1; k++) @(posedge hclk);
    chk("long pass", 0, exec_run);
    look("watchdog", 6'h38, 6'b011000, 6'h0);
    wr(OFS_ERR_STAT, 32'h1FF);
    rd(OFS_ERR_STAT, 32'h100, "trip sticky");
    done("watchdog");
    conclude();
  end
  initial begin
    #(25 * 60000);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
